//--- pkg/arith_sense_regs.svh
// Register map and field positions for the arithmetic condition and fault sense block.
// Assumes a 32-bit APB master; each register is one aligned word.
`ifndef ARITH_SENSE_REGS_SVH
`define ARITH_SENSE_REGS_SVH
`define ASN_ACC_LO_OFS      12'h000
`define ASN_ACC_HI_OFS      12'h004
`define ASN_QUO_LO_OFS      12'h008
`define ASN_QUO_HI_OFS      12'h00C
`define ASN_XCH_LO_OFS      12'h010
`define ASN_XCH_HI_OFS      12'h014
`define ASN_ADDR_OFS        12'h018
`define ASN_CTRL_OFS        12'h01C
`define ASN_COND_OFS        12'h020
`define ASN_FAULT_OFS       12'h024
`define ASN_SENSE_OFS       12'h028
`define ASN_EXP_OFS         12'h02C
// Control register bits (write 1 pulses)
`define ASN_CTL_DIV_STEP    0
`define ASN_CTL_QDONE       1
`define ASN_CTL_FIXDIV      2
`define ASN_CTL_SHIFT       3
`define ASN_CTL_ADD         4
`define ASN_CTL_FLOAT       5
`define ASN_CTL_SCALE       6
`define ASN_CTL_CLEAR       7
`define ASN_CTL_MCLEAR      8
`define ASN_CTL_SEL_INT     9
`define ASN_CTL_DESEL_INT   10
`define ASN_CTL_RETURN      11
`define ASN_CTL_CLK_OVF     12
`define ASN_CTL_SEARCH      13
`define ASN_CTL_AJUMP       14
// Fault register bits
`define ASN_FLT_DIVIDE      0
`define ASN_FLT_SHIFT       1
`define ASN_FLT_OVERFLOW    2
`define ASN_FLT_EXPONENT    3
`define ASN_FLT_CLK_OVF     4
`define ASN_FLT_INT_SEL     5
`define ASN_FLT_INT_BUSY    6
// Sense codes written to the sense register
`define ASN_SENSE_DIVIDE    3'h1
`define ASN_SENSE_SHIFT     3'h2
`define ASN_SENSE_OVERFLOW  3'h3
`define ASN_SENSE_EXPONENT  3'h4
`define ASN_SENSE_CLK_OVF   3'h5
`define ASN_WORD_W          48
`define ASN_EXP_W           11
`define ASN_SHIFT_OK_W      7
`define ASN_EXP_LIMIT       11'h3FF
`endif

//--- pkg/arith_sense_pkg.sv
// Types for the arithmetic condition and fault sense block.
// Assumes arith_sense_regs.svh supplies all numeric constants except the interrupt state encodings.
package arith_sense_pkg;
   typedef struct packed {
      logic divide;
      logic shift;
      logic overflow;
      logic exponent;
   } fault_flags_t;

   typedef struct packed {
      logic acc_ge_xch;
      logic acc_eq_xch;
      logic acc_zero;
      logic quo_zero;
      logic double_zero;
      logic acc_sign;
      logic quo_sign;
      logic xch_sign;
      logic sign_mismatch;
      logic scale_done;
      logic normalize_left;
      logic normalize_right;
      logic search_end;
      logic jump_take;
   } cond_t;

   typedef enum logic [2:0] {
      INT_IDLE = 3'b001,
      INT_RUN  = 3'b010,
      INT_WAIT = 3'b100
   } int_state_t;
endpackage

//--- design/arith_condition_and_fault_sense.sv
// Arithmetic condition sensing and sticky fault flags for a 48-bit word machine.
// Assumes an APB master loads the register images and pulses the command bits.
`timescale 1ns/100ps
`include "arith_sense_regs.svh"

// Notes on behaviour
// - Divide step subtracts and enters one if A>=X
// - Equality search ends when X equals A
// - A jump with zero designator needs A zero
// - A zero is plus zero OR minus zero
// - Double zero needs A zero and Q zero
// - Sign outputs come straight from sign bits
// - A47 differing from Q47 means quotient overflow
// - Scale done when one reaches bit 46
// - Four sticky fault flags drive indicators
// - Selected arithmetic interrupt starts on any fault
// - Divide fault needs fixdiv, Q negative, uncorrected
// - Zero divisor or sign-bit quotient is overflow
// - Shift fault when address bits above six set
// - Overflow only for like signs, sum sign changes
// - Overflow check one phase after the add
// - Exponent fault at ten-bit positive or negative limit
// - Master clear or clear instruction clears faults
// - Each fault sensed by its own code
// - Clear instruction also clears clock overflow
// - No new interrupt until return to program
// - Equality from bitwise similarity of A and X
module arith_condition_and_fault_sense (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SRST,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Console indicators and interrupt start
   output logic      [3:0]  FAULT_LAMPS,
   output logic             INT_START,
   output logic             DIV_DIGIT_ONE,
   output logic             SEARCH_END,
   output logic             JUMP_TAKE,
   output logic             SCALE_DONE
);
   localparam int W = `ASN_WORD_W;

   logic [W-1:0]                 acc;
   logic [W-1:0]                 quo;
   logic [W-1:0]                 xch;
   logic [W-1:0]                 addr;
   logic [`ASN_EXP_W-1:0]        exponent;
   logic                         add_pending;
   logic                         acc_sign_before;
   logic                         clk_ovf;
   logic                         int_selected;
   logic [2:0]                   sense_code;
   logic                         sense_hit;
   arith_sense_pkg::fault_flags_t flags;
   arith_sense_pkg::fault_flags_t set_now;
   arith_sense_pkg::cond_t       cond;
   arith_sense_pkg::int_state_t  int_state;
   arith_sense_pkg::int_state_t  next_int_state;

   wire        wr_en   = PSEL & PENABLE & PWRITE;
   wire        ctl_wr  = wr_en & (PADDR == `ASN_CTRL_OFS);
   wire [31:0] cmd     = ctl_wr ? PWDATA : 32'h0000_0000;
   wire        clr_all = cmd[`ASN_CTL_CLEAR] | cmd[`ASN_CTL_MCLEAR];

   // Condition networks, all combinational from the register images
   logic [W-1:0] similar;
   logic [W:0]   diff;
   always_comb begin
      similar = ~(acc ^ xch);
      diff    = {1'b0, acc} - {1'b0, xch};
      cond.acc_ge_xch      = ~diff[W];
      cond.acc_eq_xch      = &similar;
      cond.acc_zero        = (acc == '0) | (acc == '1);
      cond.quo_zero        = (quo == '0) | (quo == '1);
      cond.double_zero     = cond.acc_zero & cond.quo_zero;
      cond.acc_sign        = acc[W-1];
      cond.quo_sign        = quo[W-1];
      cond.xch_sign        = xch[W-1];
      cond.sign_mismatch   = acc[W-1] ^ quo[W-1];
      cond.scale_done      = acc[W-2];
      cond.normalize_left  = acc[35] == acc[36];
      cond.normalize_right = acc[36] != acc[37];
      cond.search_end      = cond.acc_eq_xch;
      cond.jump_take       = cond.acc_zero;
   end

   // Fault recognition
   always_comb begin
      // Q negative before sign correction covers zero divisor and sign-bit quotient
      set_now.divide   = cmd[`ASN_CTL_FIXDIV] & cmd[`ASN_CTL_QDONE]
                         & quo[W-1];
      set_now.shift    = cmd[`ASN_CTL_SHIFT]
                         & (|addr[W-1:`ASN_SHIFT_OK_W]);
      set_now.overflow = add_pending & (acc[W-1] != acc_sign_before);
      set_now.exponent = cmd[`ASN_CTL_FLOAT]
                         & ((exponent == `ASN_EXP_LIMIT)
                            | (exponent == ~`ASN_EXP_LIMIT));
   end

   // Sticky flags; a fault in the clear cycle survives the clear
   always_ff @(posedge CLK) begin
      if (SRST) begin
         flags <= '0;
      end else begin
         flags <= (clr_all ? '0 : flags) | set_now;
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         clk_ovf <= 1'b0;
      end else if (cmd[`ASN_CTL_CLK_OVF]) begin
         clk_ovf <= 1'b1;
      end else if (cmd[`ASN_CTL_CLEAR] | cmd[`ASN_CTL_MCLEAR]) begin
         clk_ovf <= 1'b0;
      end
   end

   // Overflow check strobe lands one cycle after the add, like-signed operands only
   always_ff @(posedge CLK) begin
      if (SRST) begin
         add_pending     <= 1'b0;
         acc_sign_before <= 1'b0;
      end else begin
         add_pending     <= cmd[`ASN_CTL_ADD] & (acc[W-1] == xch[W-1]);
         acc_sign_before <= acc[W-1];
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST | cmd[`ASN_CTL_MCLEAR]) begin
         int_selected <= 1'b0;
      end else if (cmd[`ASN_CTL_SEL_INT]) begin
         int_selected <= 1'b1;
      end else if (cmd[`ASN_CTL_DESEL_INT]) begin
         int_selected <= 1'b0;
      end
   end

   // Interrupt: one start pulse, then locked out until return
   always_comb begin
      next_int_state = int_state;
      case (int_state)
         arith_sense_pkg::INT_IDLE: begin
            if (int_selected & (|set_now)) begin
               next_int_state = arith_sense_pkg::INT_RUN;
            end
         end
         arith_sense_pkg::INT_RUN: begin
            next_int_state = arith_sense_pkg::INT_WAIT;
         end
         arith_sense_pkg::INT_WAIT: begin
            if (cmd[`ASN_CTL_RETURN]) begin
               next_int_state = arith_sense_pkg::INT_IDLE;
            end
         end
         default: begin
            next_int_state = arith_sense_pkg::INT_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST | cmd[`ASN_CTL_MCLEAR]) begin
         int_state <= arith_sense_pkg::INT_IDLE;
      end else begin
         int_state <= next_int_state;
      end
   end

   // Accumulator and quotient images: APB word loads, else divide step updates
   always_ff @(posedge CLK) begin
      if (SRST) begin
         acc <= '0;
         quo <= '0;
      end else if (wr_en & (PADDR == `ASN_ACC_LO_OFS)) begin
         acc[31:0] <= PWDATA;
      end else if (wr_en & (PADDR == `ASN_ACC_HI_OFS)) begin
         acc[W-1:32] <= PWDATA[W-33:0];
      end else if (wr_en & (PADDR == `ASN_QUO_LO_OFS)) begin
         quo[31:0] <= PWDATA;
      end else if (wr_en & (PADDR == `ASN_QUO_HI_OFS)) begin
         quo[W-1:32] <= PWDATA[W-33:0];
      end else if (cmd[`ASN_CTL_DIV_STEP]) begin
         if (cond.acc_ge_xch) begin
            acc <= diff[W-1:0];
         end
         quo <= {quo[W-2:0], cond.acc_ge_xch};
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         xch      <= '0;
         addr     <= '0;
         exponent <= '0;
      end else if (wr_en) begin
         case (PADDR)
            `ASN_XCH_LO_OFS: xch[31:0]   <= PWDATA;
            `ASN_XCH_HI_OFS: xch[W-1:32] <= PWDATA[W-33:0];
            `ASN_ADDR_OFS:   addr        <= {{(W-32){1'b0}}, PWDATA};
            `ASN_EXP_OFS:    exponent    <= PWDATA[`ASN_EXP_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Sense instruction: write a code, read back the chosen flag
   always_ff @(posedge CLK) begin
      if (SRST) begin
         sense_code <= 3'h0;
      end else if (wr_en & (PADDR == `ASN_SENSE_OFS)) begin
         sense_code <= PWDATA[2:0];
      end
   end

   always_comb begin
      case (sense_code)
         `ASN_SENSE_DIVIDE:   sense_hit = flags.divide;
         `ASN_SENSE_SHIFT:    sense_hit = flags.shift;
         `ASN_SENSE_OVERFLOW: sense_hit = flags.overflow;
         `ASN_SENSE_EXPONENT: sense_hit = flags.exponent;
         `ASN_SENSE_CLK_OVF:  sense_hit = clk_ovf;
         default:             sense_hit = 1'b0;
      endcase
   end

   // APB read path, registered; no wait states, PRDATA is loaded into a flop at the end of the setup phase
   logic [31:0] rd_mux;
   logic        addr_ok;
   always_comb begin
      addr_ok = 1'b1;
      case (PADDR)
         `ASN_ACC_LO_OFS: rd_mux = acc[31:0];
         `ASN_ACC_HI_OFS: rd_mux = {16'h0000, acc[W-1:32]};
         `ASN_QUO_LO_OFS: rd_mux = quo[31:0];
         `ASN_QUO_HI_OFS: rd_mux = {16'h0000, quo[W-1:32]};
         `ASN_XCH_LO_OFS: rd_mux = xch[31:0];
         `ASN_XCH_HI_OFS: rd_mux = {16'h0000, xch[W-1:32]};
         `ASN_ADDR_OFS:   rd_mux = addr[31:0];
         `ASN_CTRL_OFS:   rd_mux = 32'h0000_0000;
         `ASN_COND_OFS:   rd_mux = {18'h00000, cond};
         `ASN_FAULT_OFS:  rd_mux = {25'h0000000,
                                    int_state != arith_sense_pkg::INT_IDLE,
                                    int_selected, clk_ovf,
                                    flags.exponent, flags.overflow,
                                    flags.shift, flags.divide};
         `ASN_SENSE_OFS:  rd_mux = {28'h0000000, sense_hit, sense_code};
         `ASN_EXP_OFS:    rd_mux = {21'h000000, exponent};
         default: begin
            rd_mux  = 32'h0000_0000;
            addr_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL & ~PENABLE;
         PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : PRDATA;
         PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
      end
   end

   // Indicator and status outputs
   always_ff @(posedge CLK) begin
      if (SRST) begin
         FAULT_LAMPS   <= 4'h0;
         INT_START     <= 1'b0;
         DIV_DIGIT_ONE <= 1'b0;
         SEARCH_END    <= 1'b0;
         JUMP_TAKE     <= 1'b0;
         SCALE_DONE    <= 1'b0;
      end else begin
         FAULT_LAMPS   <= flags;
         INT_START     <= next_int_state == arith_sense_pkg::INT_RUN;
         DIV_DIGIT_ONE <= cmd[`ASN_CTL_DIV_STEP] & cond.acc_ge_xch;
         SEARCH_END    <= cmd[`ASN_CTL_SEARCH] & cond.search_end;
         JUMP_TAKE     <= cmd[`ASN_CTL_AJUMP] & cond.jump_take;
         SCALE_DONE    <= cmd[`ASN_CTL_SCALE] & cond.scale_done;
      end
   end
endmodule // arith_condition_and_fault_sense

//--- test/arith_sense_assertions.sv
// Port checker for the arithmetic condition and fault sense block.
// Assumes it is bound to the design top and APB requests are held until PREADY.
`timescale 1ns/100ps
`include "arith_sense_regs.svh"
module arith_sense_assertions (
   // Clock and reset
   input wire logic        CLK,
   input wire logic        SRST,
   // APB
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // Indicators and pulses
   input wire logic [3:0]  FAULT_LAMPS,
   input wire logic        INT_START,
   input wire logic        DIV_DIGIT_ONE,
   input wire logic        SEARCH_END,
   input wire logic        JUMP_TAKE,
   input wire logic        SCALE_DONE
);
   logic ctl_wr;
   logic clr_wr;
   assign ctl_wr = PSEL && PENABLE && PWRITE && PADDR == `ASN_CTRL_OFS;
   assign clr_wr = ctl_wr && (PWDATA[7] || PWDATA[8]);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   chk_ready_access: assert property (PREADY |-> PSEL && PENABLE)
      else $error("ready outside access");
   chk_err_ready: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   // Lamps trail the flags by one cycle, so a clear shows two edges after the write
   chk_lamps_sticky: assert property (!clr_wr && !$past(clr_wr) && !SRST |=>
      ($past(FAULT_LAMPS) & ~FAULT_LAMPS) == 4'h0) else $error("fault lamp dropped");
   chk_clear_lamps: assert property (clr_wr && PWDATA[5:0] == 6'h00 |=>
      ##1 FAULT_LAMPS == 4'h0) else $error("lamps not cleared");
   chk_int_fault: assert property (INT_START |=> FAULT_LAMPS != 4'h0)
      else $error("interrupt without fault");
   chk_int_once: assert property (INT_START |=> !INT_START [*3])
      else $error("repeated interrupt");
   chk_digit_cause: assert property (DIV_DIGIT_ONE |-> $past(ctl_wr && PWDATA[0]))
      else $error("stray digit pulse");
   chk_search_cause: assert property (SEARCH_END |-> $past(ctl_wr && PWDATA[13]))
      else $error("stray search end");
   chk_jump_cause: assert property (JUMP_TAKE |-> $past(ctl_wr && PWDATA[14]))
      else $error("stray jump");
   chk_scale_cause: assert property (SCALE_DONE |-> $past(ctl_wr && PWDATA[6]))
      else $error("stray scale done");
   cov_int: cover property (INT_START);
   cov_err: cover property (PSLVERR);
   cov_scale: cover property (SCALE_DONE);
endmodule // arith_sense_assertions

//--- test/tb.sv
// Self-checking bench for the arithmetic condition and fault sense block.
// Assumes the register header is on the include path.
`timescale 1ns/100ps
`include "arith_sense_regs.svh"
module tb;
   logic        CLK = 0, SRST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic        PREADY, PSLVERR, INT_START, DIV_DIGIT_ONE, SEARCH_END, JUMP_TAKE, SCALE_DONE;
   logic [3:0]  FAULT_LAMPS;
   logic [4:0]  cap;
   logic        cap_clr = 0, err;
   int          failures = 0, n_tests = 0;
   typedef struct {logic [47:0] a, q, x; logic [31:0] c; logic [4:0] p; logic [13:0] k;} row_t;
   // Pulses packed as {int, digit, search, jump, scale}
   row_t rows [7] = '{
      '{48'h0, 48'h0, 48'h0, 32'h4000, 5'h02, 14'h3E03},
      '{48'hFFFFFFFFFFFF, 48'h1, 48'hFFFFFFFFFFFF, 32'h2000, 5'h04, 14'h3973},
      '{48'h5, 48'h800000000000, 48'h3, 32'h0001, 5'h08, 14'h20A0},
      '{48'h3, 48'h0, 48'h5, 32'h0001, 5'h00, 14'h0400},
      '{48'h1, 48'h0, 48'h1, 32'h4000, 5'h00, 14'h3402},
      '{48'h400000000000, 48'h0, 48'h0, 32'h0040, 5'h01, 14'h2410},
      '{48'h2, 48'h0, 48'h3, 32'h2000, 5'h00, 14'h0400}};
   arith_condition_and_fault_sense arith_condition_and_fault_sense_i (
      .CLK(CLK), .SRST(SRST),
      .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .FAULT_LAMPS(FAULT_LAMPS), .INT_START(INT_START), .DIV_DIGIT_ONE(DIV_DIGIT_ONE),
      .SEARCH_END(SEARCH_END), .JUMP_TAKE(JUMP_TAKE), .SCALE_DONE(SCALE_DONE));
   always #10 CLK = ~CLK;
   // Sticky capture, so a pulse cannot slip between two samples
   always @(posedge CLK) begin
      cap <= cap_clr ? 5'h00 : cap | {INT_START, DIV_DIGIT_ONE, SEARCH_END, JUMP_TAKE, SCALE_DONE};
   end
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK);
      PSEL <= 1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (PREADY !== 1'b1 && n < 20);
      if (PREADY !== 1'b1) begin
         failures++;
         end_sim();
      end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
   endtask
   task automatic ld(input logic [47:0] a, input logic [47:0] q, input logic [47:0] x);
      apb(1, `ASN_ACC_LO_OFS, a[31:0]);
      apb(1, `ASN_ACC_HI_OFS, {16'h0, a[47:32]});
      apb(1, `ASN_QUO_LO_OFS, q[31:0]);
      apb(1, `ASN_QUO_HI_OFS, {16'h0, q[47:32]});
      apb(1, `ASN_XCH_LO_OFS, x[31:0]);
      apb(1, `ASN_XCH_HI_OFS, {16'h0, x[47:32]});
   endtask
   task automatic cmd(input logic [31:0] c);
      cap_clr <= 1;
      @(posedge CLK);
      cap_clr <= 0;
      apb(1, `ASN_CTRL_OFS, c);
      repeat (3) @(posedge CLK);
   endtask
   task automatic sn(input logic [2:0] code, input logic hit);
      apb(1, `ASN_SENSE_OFS, {29'h0, code});
      apb(0, `ASN_SENSE_OFS, 32'h0);
      chk(rd[3], hit);
   endtask
   initial begin
      repeat (12) @(posedge CLK);
      SRST <= 0;
      chk(FAULT_LAMPS, 4'h0);
      apb(0, `ASN_FAULT_OFS, 32'h0);
      chk(rd, 32'h0);
      foreach (rows[i]) begin
         ld(rows[i].a, rows[i].q, rows[i].x);
         apb(0, `ASN_COND_OFS, 32'h0);
         chk(rd & 32'h3FF3, rows[i].k);
         cmd(rows[i].c);
         chk(cap, rows[i].p);
         $display("row %0d done", i);
      end
      ld(48'h0, 48'h800000000000, 48'h1);
      cmd(32'h2);
      chk(FAULT_LAMPS, 4'h0);
      cmd(32'h6);
      chk(FAULT_LAMPS, 4'h8);
      cmd(32'h6);
      chk(FAULT_LAMPS, 4'h8);
      sn(3'h1, 1'b1);
      sn(3'h2, 1'b0);
      apb(1, `ASN_ADDR_OFS, 32'h7F);
      cmd(32'h8);
      chk(FAULT_LAMPS, 4'h8);
      apb(1, `ASN_ADDR_OFS, 32'h80);
      cmd(32'h8);
      chk(FAULT_LAMPS, 4'hC);
      // The divide step flips the accumulator sign in the same cycle as the add
      ld(48'h800000000000, 48'h0, 48'h1);
      cmd(32'h11);
      chk(FAULT_LAMPS, 4'hC);
      ld(48'h800000000001, 48'h0, 48'h800000000000);
      cmd(32'h11);
      chk(FAULT_LAMPS, 4'hE);
      sn(3'h3, 1'b1);
      apb(1, `ASN_EXP_OFS, 32'h3FE);
      cmd(32'h20);
      chk(FAULT_LAMPS, 4'hE);
      apb(1, `ASN_EXP_OFS, 32'h3FF);
      cmd(32'h20);
      chk(FAULT_LAMPS, 4'hF);
      sn(3'h4, 1'b1);
      cmd(32'h1000);
      sn(3'h5, 1'b1);
      cmd(32'h80);
      chk(FAULT_LAMPS, 4'h0);
      sn(3'h5, 1'b0);
      $display("fault flag tests done");
      cmd(32'h200);
      apb(1, `ASN_EXP_OFS, 32'h400);
      cmd(32'h20);
      chk(cap, 5'h10);
      cmd(32'h8);
      chk(cap, 5'h00);
      apb(0, `ASN_FAULT_OFS, 32'h0);
      chk(rd, 32'h6A);
      cmd(32'h800);
      cmd(32'h80);
      cmd(32'h8);
      chk(cap, 5'h10);
      cmd(32'h100);
      chk(FAULT_LAMPS, 4'h0);
      apb(0, `ASN_FAULT_OFS, 32'h0);
      chk(rd, 32'h0);
      cmd(32'h8);
      chk(cap, 5'h00);
      cmd(32'h200);
      cmd(32'h400);
      cmd(32'h8);
      chk(cap, 5'h00);
      $display("interrupt tests done");
      SRST <= 1;
      repeat (2) @(posedge CLK);
      SRST <= 0;
      chk(FAULT_LAMPS, 4'h0);
      apb(0, 12'h030, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      apb(0, `ASN_CTRL_OFS, 32'h0);
      chk({err, rd}, 33'h0);
      $display("bus tests done");
      end_sim();
   end
endmodule // tb
bind arith_condition_and_fault_sense arith_sense_assertions chk_i (.CLK, .SRST, .PSEL,
   .PENABLE, .PWRITE, .PADDR, .PWDATA, .PREADY, .PSLVERR, .FAULT_LAMPS, .INT_START,
   .DIV_DIGIT_ONE, .SEARCH_END, .JUMP_TAKE, .SCALE_DONE);
